// file: rtl/frp_cfg.svh
// Opcodes, phase lengths, reset values and timing counts of the command block
`ifndef FRP_CFG_SVH
`define FRP_CFG_SVH

`define FRP_CLK_MHZ          50

`define FRP_OP_SUSPEND       8'h75
`define FRP_OP_RESUME        8'h7a
`define FRP_OP_PWR_DOWN      8'hb9
`define FRP_OP_RELEASE_ID    8'hab
`define FRP_OP_MFR_DEV       8'h90
`define FRP_OP_MFR_DEV_DUAL  8'h92
`define FRP_OP_MFR_DEV_QUAD  8'h94
`define FRP_OP_UNIQUE_ID     8'h4b

`define FRP_CMD_BITS         8
`define FRP_ID_DUMMY_BITS    24
`define FRP_ADDR3_BITS       24
`define FRP_ADDR4_BITS       32
`define FRP_MODE_BITS        8
`define FRP_QUAD_DUMMY_CLKS  4
`define FRP_UID_DUMMY3_BITS  32
`define FRP_UID_DUMMY4_BITS  40
`define FRP_DEV_ID_BITS      8
`define FRP_MFR_DEV_BITS     16
`define FRP_UID_BITS         64

// Pin synchroniser reset value, order {io[3:0], sck, cs_n}
`define FRP_PINS_RST         6'h01

// Longest time: round down
`define FRP_BUSY_SET_NS      200
`define FRP_BUSY_SET_CYC     ((`FRP_BUSY_SET_NS * `FRP_CLK_MHZ) / 1000)
`define FRP_TDP_NS           3000
`define FRP_TDP_CYC          ((`FRP_TDP_NS * `FRP_CLK_MHZ) / 1000)
// Least time: round up
`define FRP_POWERDOWN_RELEASE_TIME_NS         3000
`define FRP_POWERDOWN_RELEASE_TIME_CYC        ((`FRP_POWERDOWN_RELEASE_TIME_NS * `FRP_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/frp_pkg.sv
// Types shared by the command block
package frp_pkg;

    typedef enum logic [1:0] {
        ST_CMD,
        ST_PRE,
        ST_DATA,
        ST_SKIP
    } frp_state_t;

    typedef logic [2:0] frp_lanes_t;

endpackage : frp_pkg

// file: rtl/frp_pin_if.sv
// Synchronised serial pins passed from the synchroniser to the core
`timescale 1ns/100ps
interface frp_pin_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
    modport src (output cs_n, output sck, output io);
    modport dst (input cs_n, input sck, input io);
endinterface : frp_pin_if

// file: rtl/frp_pin_sync.sv
// Two-flop synchroniser for the host-driven serial pins
`timescale 1ns/100ps
`include "frp_cfg.svh"
module frp_pin_sync import frp_pkg::*; (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // Raw pins
    input  wire logic       i_cs_n,
    input  wire logic       i_sck,
    input  wire logic [3:0] i_io,
    // Synchronised pins
    frp_pin_if.src          o_pins
);
    localparam logic [5:0] PINS_RST = `FRP_PINS_RST;

    logic [5:0] raw;
    logic [5:0] sync_q;

    assign raw = {i_io, i_sck, i_cs_n};

    // First flop feeds only the second
    for (genvar g = 0; g < 6; g++) begin : g_bit
        logic meta_q;
        logic hold_q;
        always_ff @(posedge i_clk) begin
            if (!i_rstn) begin
                meta_q <= PINS_RST[g];
                hold_q <= PINS_RST[g];
            end else begin
                meta_q <= raw[g];
                hold_q <= meta_q;
            end
        end
        assign sync_q[g] = hold_q;
    end

    assign o_pins.cs_n = sync_q[0];
    assign o_pins.sck  = sync_q[1];
    assign o_pins.io   = sync_q[5:2];

endmodule : frp_pin_sync

// file: rtl/frp_cmd_core.sv
// Resume, power-down and identification command handling of the serial flash
//
// Functional notes
// - Resume accepted only with suspend set, not busy
// - Resume clears suspend, busy within 200 ns
// - Resume ignored if suspend clear or busy
// - Resume ignored after power loss in suspend
// - Power-down needs chip select high after bit eight
// - Power-down entered within the entry time
// - Powered down, only the release is recognised
// - Reset always leaves normal operation
// - Release waits its time before new instructions
// - Device ID after three dummy bytes, repeated
// - Manufacturer then device ID after zero address
// - Dual read, two bits per clock, alternating
// - Quad read, four dummy clocks, four bits
// - Dual and quad address grows in four-byte mode
// - Unique number after four dummy bytes
// - Five dummy bytes in four-byte mode
// - Suspend accepted only unsuspended and busy
`timescale 1ns/100ps
`include "frp_cfg.svh"
module frp_cmd_core import frp_pkg::*; #(
    parameter logic [7:0]  MFR_ID    = 8'h5a,                 // Arbitrary value
    parameter logic [7:0]  DEV_ID    = 8'h3c,                 // Arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // Serial pins
    input  wire logic       i_cs_n,
    input  wire logic       i_sck,
    input  wire logic [3:0] i_io,
    output logic      [3:0] o_io,
    output logic      [3:0] o_io_oe,
    // Erase and program engine
    input  wire logic       i_busy,
    input  wire logic       i_power_lost,
    input  wire logic       i_addr4b,
    output logic            o_suspend_req,
    output logic            o_resume_req,
    // Status
    output logic            o_suspend_flag,
    output logic            o_busy,
    output logic            o_powered_down
);
    localparam logic [15:0] TDP_CYC   = 16'(`FRP_TDP_CYC);
    localparam logic [15:0] POWERDOWN_RELEASE_TIME_CYC = 16'(`FRP_POWERDOWN_RELEASE_TIME_CYC);
    localparam int          TDP_LIM   = `FRP_TDP_CYC + 1;
    localparam int          BUSY_LIM  = `FRP_BUSY_SET_CYC - 1;

    frp_pin_if pins ();

    frp_pin_sync u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_cs_n (i_cs_n),
        .i_sck  (i_sck),
        .i_io   (i_io),
        .o_pins (pins)
    );

    frp_state_t  st_q;
    frp_state_t  dec_st;
    logic        sck_d_q;
    logic        cs_d_q;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic [7:0]  cmd_q;
    logic [7:0]  cmd_full;
    logic [5:0]  bits_q;
    logic [5:0]  pre_cnt_q;
    logic [5:0]  pre_len_q;
    logic [5:0]  pre_len_d;
    frp_lanes_t  lanes_q;
    frp_lanes_t  lanes_d;
    logic [6:0]  plen_q;
    logic [6:0]  plen_d;
    logic [63:0] pat_q;
    logic [63:0] pat_d;
    logic [63:0] sr_q;
    logic [6:0]  out_cnt_q;
    logic [6:0]  out_nxt;
    logic        pre_last;
    logic        blocked;
    logic        frame8;
    logic        exec_pd;
    logic        exec_rel;
    logic        exec_sus;
    logic        exec_res;
    logic        pd_pend_q;
    logic [15:0] pd_cnt_q;
    logic [15:0] rel_cnt_q;
    logic        lost_q;
    logic        res_wait_q;

    // Edges of the sampled serial clock; the link clock idles outside frames
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sck_d_q <= 1'b0;
            cs_d_q  <= 1'b1;
        end else begin
            sck_d_q <= pins.sck;
            cs_d_q  <= pins.cs_n;
        end
    end

    assign sck_rise = pins.sck & ~sck_d_q & ~pins.cs_n;
    assign sck_fall = ~pins.sck & sck_d_q & ~pins.cs_n;
    assign cs_rise  = pins.cs_n & ~cs_d_q;

    // Powered down, entering or releasing: no instruction is decoded but the frame-end release, taken when powered down
    assign blocked  = o_powered_down | pd_pend_q | (rel_cnt_q != 16'h0000);
    assign cmd_full = {cmd_q[6:0], pins.io[0]};
    assign pre_last = (pre_cnt_q == pre_len_q - 6'h01);

    // Opcode decode on the eighth rising edge
    always_comb begin
        dec_st    = ST_SKIP;
        pre_len_d = 6'h00;
        lanes_d   = 3'h1;
        plen_d    = 7'(`FRP_DEV_ID_BITS);
        pat_d     = 64'h0;
        if (!blocked) begin
            unique case (cmd_full)
                `FRP_OP_RELEASE_ID: begin
                    dec_st    = ST_PRE;
                    pre_len_d = 6'(`FRP_ID_DUMMY_BITS);
                    pat_d     = {DEV_ID, 56'h0};
                end
                `FRP_OP_MFR_DEV: begin
                    dec_st    = ST_PRE;
                    pre_len_d = 6'(`FRP_ADDR3_BITS);
                    plen_d    = 7'(`FRP_MFR_DEV_BITS);
                    pat_d     = {MFR_ID, DEV_ID, 48'h0};
                end
                `FRP_OP_MFR_DEV_DUAL: begin
                    dec_st    = ST_PRE;
                    lanes_d   = 3'h2;
                    plen_d    = 7'(`FRP_MFR_DEV_BITS);
                    pat_d     = {MFR_ID, DEV_ID, 48'h0};
                    // Mode byte is clocked in but not acted on
                    pre_len_d = i_addr4b ?
                        6'((`FRP_ADDR4_BITS + `FRP_MODE_BITS) / 2) :
                        6'((`FRP_ADDR3_BITS + `FRP_MODE_BITS) / 2);
                end
                `FRP_OP_MFR_DEV_QUAD: begin
                    dec_st    = ST_PRE;
                    lanes_d   = 3'h4;
                    plen_d    = 7'(`FRP_MFR_DEV_BITS);
                    pat_d     = {MFR_ID, DEV_ID, 48'h0};
                    pre_len_d = i_addr4b ?
                        6'(`FRP_QUAD_DUMMY_CLKS + (`FRP_ADDR4_BITS + `FRP_MODE_BITS) / 4) :
                        6'(`FRP_QUAD_DUMMY_CLKS + (`FRP_ADDR3_BITS + `FRP_MODE_BITS) / 4);
                end
                `FRP_OP_UNIQUE_ID: begin
                    dec_st    = ST_PRE;
                    plen_d    = 7'(`FRP_UID_BITS);
                    pat_d     = UNIQUE_ID;
                    pre_len_d = i_addr4b ? 6'(`FRP_UID_DUMMY4_BITS) :
                                           6'(`FRP_UID_DUMMY3_BITS);
                end
                default: dec_st = ST_SKIP;
            endcase
        end
    end

    // Frame state; chip select high always restarts at the opcode
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_q <= ST_CMD;
        end else if (pins.cs_n) begin
            st_q <= ST_CMD;
        end else begin
            unique case (st_q)
                ST_CMD: begin
                    if (sck_rise && bits_q == 6'h07) begin
                        st_q <= dec_st;
                    end
                end
                ST_PRE: begin
                    if (sck_rise && pre_last) begin
                        st_q <= ST_DATA;
                    end
                end
                ST_DATA: st_q <= ST_DATA;
                ST_SKIP: st_q <= ST_SKIP;
            endcase
        end
    end

    // Opcode shift, MSB first on rising edges
    always_ff @(posedge i_clk) begin
        if (!i_rstn || pins.cs_n) begin
            cmd_q  <= 8'h00;
            bits_q <= 6'h00;
        end else if (sck_rise) begin
            if (st_q == ST_CMD) begin
                cmd_q <= cmd_full;
            end
            if (bits_q != 6'h3f) begin
                bits_q <= bits_q + 6'h01;
            end
        end
    end

    // Address, mode and dummy clocks are counted, not stored
    always_ff @(posedge i_clk) begin
        if (!i_rstn || pins.cs_n) begin
            pre_cnt_q <= 6'h00;
        end else if (sck_rise && st_q == ST_PRE) begin
            pre_cnt_q <= pre_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pre_len_q <= 6'h00;
            lanes_q   <= 3'h1;
            plen_q    <= 7'(`FRP_DEV_ID_BITS);
            pat_q     <= 64'h0;
        end else if (st_q == ST_CMD && sck_rise && bits_q == 6'h07) begin
            pre_len_q <= pre_len_d;
            lanes_q   <= lanes_d;
            plen_q    <= plen_d;
            pat_q     <= pat_d;
        end
    end

    // Read-out: pattern repeats until chip select rises
    assign out_nxt = out_cnt_q + {4'h0, lanes_q};

    always_ff @(posedge i_clk) begin
        if (!i_rstn || pins.cs_n) begin
            sr_q      <= 64'h0;
            out_cnt_q <= 7'h00;
            o_io      <= 4'h0;
            o_io_oe   <= 4'h0;
        end else if (st_q == ST_PRE && sck_rise && pre_last) begin
            sr_q      <= pat_q;
            out_cnt_q <= 7'h00;
        end else if (st_q == ST_DATA && sck_fall) begin
            unique case (lanes_q)
                3'h4: begin
                    o_io    <= sr_q[63:60];
                    o_io_oe <= 4'hf;
                end
                3'h2: begin
                    o_io    <= {2'h0, sr_q[63:62]};
                    o_io_oe <= 4'h3;
                end
                default: begin
                    o_io    <= {2'h0, sr_q[63], 1'b0};
                    o_io_oe <= 4'h2;
                end
            endcase
            if (out_nxt >= plen_q) begin
                sr_q      <= pat_q;
                out_cnt_q <= 7'h00;
            end else begin
                sr_q      <= sr_q << lanes_q;
                out_cnt_q <= out_nxt;
            end
        end
    end

    // Frame-end instructions act only on exactly eight bits
    assign frame8   = cs_rise && bits_q == 6'(`FRP_CMD_BITS);
    assign exec_pd  = frame8 && cmd_q == `FRP_OP_PWR_DOWN && !blocked;
    assign exec_rel = frame8 && cmd_q == `FRP_OP_RELEASE_ID && o_powered_down && !pd_pend_q;
    assign exec_sus = frame8 && cmd_q == `FRP_OP_SUSPEND && !blocked
                      && !o_suspend_flag && o_busy;
    assign exec_res = frame8 && cmd_q == `FRP_OP_RESUME && !blocked
                      && o_suspend_flag && !o_busy && !lost_q;

    // Power-down entry and release timing
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_powered_down <= 1'b0;
            pd_pend_q      <= 1'b0;
            pd_cnt_q       <= 16'h0000;
        end else if (exec_pd) begin
            pd_pend_q <= 1'b1;
            pd_cnt_q  <= TDP_CYC - 16'h0001;
        end else if (pd_pend_q) begin
            if (pd_cnt_q == 16'h0000) begin
                pd_pend_q      <= 1'b0;
                o_powered_down <= 1'b1;
            end else begin
                pd_cnt_q <= pd_cnt_q - 16'h0001;
            end
        end else if (exec_rel) begin
            o_powered_down <= 1'b0;
        end
    end

    // Reads whose eighth rising edge and frame-end instructions whose chip select rise fall in release are dropped
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rel_cnt_q <= 16'h0000;
        end else if (exec_rel) begin
            rel_cnt_q <= POWERDOWN_RELEASE_TIME_CYC;
        end else if (rel_cnt_q != 16'h0000) begin
            rel_cnt_q <= rel_cnt_q - 16'h0001;
        end
    end

    // Suspend flag: a set wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_suspend_flag <= 1'b0;
        end else if (exec_sus) begin
            o_suspend_flag <= 1'b1;
        end else if (exec_res || i_power_lost) begin
            o_suspend_flag <= 1'b0;
        end
    end

    // Power loss poisons any pending resume until the next suspend
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            lost_q <= 1'b0;
        end else if (i_power_lost) begin
            lost_q <= 1'b1;
        end else if (exec_sus) begin
            lost_q <= 1'b0;
        end
    end

    // Busy is forced until the engine takes over, hiding its restart latency
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            res_wait_q <= 1'b0;
            o_busy     <= 1'b0;
        end else begin
            if (exec_res) begin
                res_wait_q <= 1'b1;
            end else if (i_busy) begin
                res_wait_q <= 1'b0;
            end
            o_busy <= i_busy | exec_res | res_wait_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_suspend_req <= 1'b0;
            o_resume_req  <= 1'b0;
        end else begin
            o_suspend_req <= exec_sus;
            o_resume_req  <= exec_res;
        end
    end

    a_resume_gate: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        o_resume_req |-> $past(o_suspend_flag) && !$past(o_busy) && !$past(lost_q))
        else $error("resume taken without suspend set and idle");

    a_resume_ignored: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (frame8 && cmd_q == `FRP_OP_RESUME && (!o_suspend_flag || o_busy)) |=> !o_resume_req)
        else $error("resume not ignored");

    a_resume_flag_busy: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(o_resume_req) |-> !o_suspend_flag ##0 (##[0:BUSY_LIM] o_busy))
        else $error("resume did not clear suspend or raise busy in time");

    a_resume_lost: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        lost_q |-> !exec_res)
        else $error("resume taken after power loss");

    a_pd_exact: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(pd_pend_q) |-> $past(cmd_q) == `FRP_OP_PWR_DOWN && $past(bits_q) == 6'h08)
        else $error("power-down started without an exact opcode frame");

    a_pd_entry: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(pd_pend_q) |-> ##[1:TDP_LIM] o_powered_down)
        else $error("power-down not entered in time");

    a_pd_silent: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        o_powered_down |-> st_q != ST_PRE && st_q != ST_DATA && o_io_oe == 4'h0)
        else $error("instruction decoded while powered down");

    a_reset_normal: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(i_rstn) |-> !o_powered_down)
        else $error("left reset powered down");

    a_release_wait: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $fell(o_powered_down) |-> (rel_cnt_q != 16'h0000 && st_q != ST_PRE) [*8])
        else $error("instruction accepted during release time");

    a_suspend_gate: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(o_suspend_flag) |-> $past(cmd_q) == `FRP_OP_SUSPEND && $past(o_busy))
        else $error("suspend set without a valid suspend instruction");

    a_lane_enable: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (o_io_oe != 4'h0) |-> (lanes_q == 3'h2 && o_io_oe == 4'h3)
            || (lanes_q == 3'h4 && o_io_oe == 4'hf) || (lanes_q == 3'h1 && o_io_oe == 4'h2))
        else $error("output lanes do not match the read width");

endmodule : frp_cmd_core

// file: tb/frp_host_model.sv
// Behavioural serial host that frames instructions into the command block
`timescale 1ns/100ps
module frp_host_model (
    // Clock
    input  wire logic       i_clk,
    // Resolved data pins
    input  wire logic [3:0] i_io,
    // Host-driven pins
    output logic            o_cs_n,
    output logic            o_sck,
    output logic      [3:0] o_io,
    output logic      [3:0] o_io_oe
);
    initial begin
        o_cs_n  = 1'b1;
        o_sck   = 1'b0;
        o_io    = 4'h0;
        o_io_oe = 4'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clk);
    endtask : wait_clk

    // Low phase of 5 clk so read data settles before it is taken
    task automatic frame(input logic [7:0] op, input int nz, input int no, input int lin,
                         input int nrd, input int lout, output logic [63:0] rd);
        logic [3:0] m;
        int         i;
        m = (lin == 4) ? 4'hf : (lin == 2) ? 4'h3 : 4'h1;
        rd = '0;
        o_cs_n = 1'b0;
        wait_clk(3);
        for (i = 0; i < 8 + nz + no + nrd; i++) begin
            o_io_oe = (i < 8) ? 4'h1 : (i < 8 + nz + no) ? m : 4'h0;
            o_io = (i < 8) ? {3'h0, op[7 - i]} : (i < 8 + nz) ? 4'h0 : 4'hf;
            wait_clk(5);
            if (i >= 8 + nz + no) begin
                rd = (lout == 4) ? {rd[59:0], i_io} :
                     (lout == 2) ? {rd[61:0], i_io[1:0]} : {rd[62:0], i_io[1]};
            end
            o_sck = 1'b1;
            wait_clk(3);
            o_sck = 1'b0;
        end
        wait_clk(3);
        o_cs_n = 1'b1;
        o_io_oe = 4'h0;
        wait_clk(4);
    endtask : frame
endmodule : frp_host_model

// file: tb/tb_flash_resume_powerdown_id_cmds.sv
// Self-checking bench of the resume, power-down and identification commands
`timescale 1ns/100ps
`define CHK(g, e) check((g), (e))
module tb_flash_resume_powerdown_id_cmds;
    localparam logic [7:0]  MFR = 8'ha7;                // Arbitrary value
    localparam logic [7:0]  DEV = 8'h19;                // Arbitrary value
    localparam logic [63:0] UID = 64'hfeed_0bad_1357_2468; // Arbitrary value
    logic        i_clk;
    logic        i_rstn;
    logic        cs_n;
    logic        sck;
    logic [3:0]  h_io;
    logic [3:0]  h_oe;
    logic [3:0]  d_io;
    logic [3:0]  d_oe;
    logic [3:0]  io_w;
    logic [3:0]  pat = 4'h5;
    logic        busy;
    logic        plost;
    logic        a4b;
    logic        sreq;
    logic        rreq;
    logic        sflag;
    logic        obusy;
    logic        pdn;
    logic        oe_seen = 1'b0;
    logic [63:0] rd;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          n_res = 0;
    int          n_sus = 0;
    int          cyc = 0;
    int          rnd;
    int          j;
    int          k;

    initial i_clk = 1'b0;
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) pat <= ~pat;
    // Released lines toggle so a stale value never passes for data
    assign io_w = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & pat);

    frp_host_model host (
        .i_clk   (i_clk),
        .i_io    (io_w),
        .o_cs_n  (cs_n),
        .o_sck   (sck),
        .o_io    (h_io),
        .o_io_oe (h_oe)
    );

    frp_cmd_core #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID)) dut (
        .i_clk          (i_clk),
        .i_rstn         (i_rstn),
        .i_cs_n         (cs_n),
        .i_sck          (sck),
        .i_io           (io_w),
        .o_io           (d_io),
        .o_io_oe        (d_oe),
        .i_busy         (busy),
        .i_power_lost   (plost),
        .i_addr4b       (a4b),
        .o_suspend_req  (sreq),
        .o_resume_req   (rreq),
        .o_suspend_flag (sflag),
        .o_busy         (obusy),
        .o_powered_down (pdn)
    );

    task automatic check(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH at %0t got %h exp %h", $time, g, e);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // Pulse counters and hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (sreq === 1'b1) n_sus++;
        if (rreq === 1'b1) n_res++;
        if (d_oe !== 4'h0) oe_seen = 1'b1;
        if (cyc == 60000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        i_rstn = 1'b0;
        busy = 1'b0;
        plost = 1'b0;
        a4b = 1'b0;
        rnd = $urandom(42);
        repeat (8) @(negedge i_clk);
        i_rstn = 1'b1;
        host.wait_clk(4);
        `CHK(pdn, 1'b0);
        host.frame(8'h75, 0, 0, 1, 0, 1, rd);
        `CHK(sflag, 1'b0);
        busy = 1'b1;
        host.frame(8'h75, 0, 0, 1, 0, 1, rd);
        `CHK(sflag, 1'b1);
        `CHK(n_sus, 1);
        host.frame(8'h7a, 0, 0, 1, 0, 1, rd);
        `CHK(n_res, 0);
        busy = 1'b0;
        host.wait_clk(3);
        host.frame(8'h7a, 0, 0, 1, 0, 1, rd);
        host.wait_clk(4);
        `CHK(n_res, 1);
        `CHK(sflag, 1'b0);
        `CHK(obusy, 1'b1);
        busy = 1'b1;
        host.wait_clk(4);
        busy = 1'b0;
        host.frame(8'h7a, 0, 0, 1, 0, 1, rd);
        `CHK(n_res, 1);
        // Power lost while suspended: resume must stay refused
        // Gap stands in for the minimum suspend interval after a resume
        host.wait_clk(50);
        busy = 1'b1;
        host.frame(8'h75, 0, 0, 1, 0, 1, rd);
        `CHK(sflag, 1'b1);
        plost = 1'b1;
        host.wait_clk(1);
        plost = 1'b0;
        busy = 1'b0;
        `CHK(sflag, 1'b0);
        host.frame(8'h7a, 0, 0, 1, 0, 1, rd);
        `CHK(n_res, 1);
        host.frame(8'hb9, 1, 0, 1, 0, 1, rd);
        host.wait_clk(170);
        `CHK(pdn, 1'b0);
        host.frame(8'hb9, 0, 0, 1, 0, 1, rd);
        host.wait_clk(160);
        `CHK(pdn, 1'b1);
        oe_seen = 1'b0;
        host.frame(8'h90, 24, 0, 1, 32, 1, rd);
        `CHK(oe_seen, 1'b0);
        host.frame(8'hab, 0, 0, 1, 0, 1, rd);
        `CHK(pdn, 1'b0);
        // Frame inside the release time is dropped
        oe_seen = 1'b0;
        host.frame(8'h90, 24, 0, 1, 32, 1, rd);
        `CHK(oe_seen, 1'b0);
        host.wait_clk(160);
        // Every read once in each address mode, then a random mix
        for (j = 0; j < 20; j++) begin
            k = (j < 10) ? j % 5 : int'($urandom % 5);
            a4b = (j < 5) ? 1'b1 : (j < 10) ? 1'b0 : 1'($urandom % 2);
            case (k)
                0: begin
                    host.frame(8'hab, 24, 0, 1, 16, 1, rd);
                    `CHK(rd[15:0], {DEV, DEV});
                end
                1: begin
                    host.frame(8'h90, 24, 0, 1, 32, 1, rd);
                    `CHK(rd[31:0], {MFR, DEV, MFR, DEV});
                end
                2: begin
                    host.frame(8'h92, a4b ? 16 : 12, 4, 2, 16, 2, rd);
                    `CHK(rd[31:0], {MFR, DEV, MFR, DEV});
                end
                3: begin
                    host.frame(8'h94, a4b ? 12 : 10, 2, 4, 8, 4, rd);
                    `CHK(rd[31:0], {MFR, DEV, MFR, DEV});
                end
                default: begin
                    host.frame(8'h4b, a4b ? 40 : 32, 0, 1, 64, 1, rd);
                    `CHK(rd, UID);
                end
            endcase
        end
        conclude();
    end
endmodule : tb_flash_resume_powerdown_id_cmds
